// ---- common/pg_pkg.sv ----
package pg_pkg;

   // four operating modes, latched from the timing-pin straps
   typedef enum logic [3:0] {
      MODE_ENERGY = 4'h1,
      MODE_EVENT1 = 4'h2,
      MODE_EVENT2 = 4'h4,
      MODE_TIMER  = 4'h8
   } op_mode_t;

   localparam int  TIMER_W     = 24;
   localparam int  CLOCK_HZ    = 10_000_000;
   localparam int  CLOCK_NS    = 1_000_000_000 / CLOCK_HZ;
   localparam logic [TIMER_W-1:0] TIMER_ZERO = 24'h000000;
   localparam logic [TIMER_W-1:0] TIMER_ONE  = 24'h000001;

endpackage : pg_pkg

// ---- hdl/power_gating_sequencer.sv ----
// How it works
// - in both event modes load one switches follow energy driven behaviour
// - event mode 1, harvest: store-to-load-two closes while wake is high
// - event mode 1, battery: battery-to-load-two closes while wake is high
// - event mode 1: wake ignored for load two while hold-off runs
// - event mode 1: hold-off starts on upper or detect threshold, ends after duration
// - hold-off duration is a configurable input
// - event mode 2: on-window starts on wake rising, ends after duration
// - event mode 2, harvest: lower threshold clears hold-off and on-window
// - event mode 2, harvest: store-to-load-two closed only while on-window counts
// - event mode 2, battery: battery-to-load-two closed only while on-window counts
// - event mode 2: wake cannot start on-window while hold-off counts
// - timer mode: first threshold detection starts hold-off and on-window
// - timer mode: off-interval completion restarts hold-off and on-window
// - timer mode: on-window completion starts off-interval, which then ends
// - on-window and off-interval durations are separate inputs
// - timer mode, harvest: lower threshold clears two timers; supply loss clears third
// - battery, event 2 or timer mode: undetect threshold clears all timers
// - timer mode, harvest: store-to-load-one closed during on-window, open in off-interval
// - timer mode, harvest: store-to-load-two on in on-window after hold-off ends
// - timer mode, battery: battery-to-load-one closed during on-window only
// - timer mode, battery: battery-to-load-two on in on-window after hold-off ends
// - one flag per timer shows counting; timer-mode switches derive from flags
// - mode latched when internal supply is first detected, from two straps
// - energy mode, harvest: store switches on from upper to lower threshold
// - energy mode, battery: battery switches on from detect to undetect threshold
`timescale 1ns/1ps
`default_nettype none
module power_gating_sequencer
   import pg_pkg::*;
(
   input  wire logic               clock,
   input  wire logic               sys_rst,
   input  wire logic               battery_input_sel,
   input  wire logic               internal_supply_detect,
   input  wire logic               on_window_strap,
   input  wire logic               off_interval_strap,
   input  wire logic               upper_storage_threshold,
   input  wire logic               lower_storage_threshold,
   input  wire logic               power_detect_threshold,
   input  wire logic               power_undetect_threshold,
   input  wire logic               wake_request,
   input  wire logic [TIMER_W-1:0] hold_off_duration,
   input  wire logic [TIMER_W-1:0] on_window_duration,
   input  wire logic [TIMER_W-1:0] off_interval_duration,
   output logic [3:0]              op_mode,
   output logic                    hold_off_timer_flag,
   output logic                    on_window_timer_flag,
   output logic                    off_interval_timer_flag,
   output logic                    store_to_load_one_switch,
   output logic                    store_to_load_two_switch,
   output logic                    battery_to_load_one_switch,
   output logic                    battery_to_load_two_switch
);

   typedef struct packed {
      logic [5:0]         in_q;
      op_mode_t           mode;
      logic               mode_set;
      logic               energy_on;
      logic               first_done;
      logic [2:0]         run;
      logic [TIMER_W-1:0] cnt0;
      logic [TIMER_W-1:0] cnt1;
      logic [TIMER_W-1:0] cnt2;
      logic [3:0]         sw;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic [5:0] in_now;
   logic [5:0] rise;
   logic       harvest;
   logic       up_ev;
   logic       lo_ev;
   logic       wake_ev;
   logic       supply_loss;
   logic [2:0] done;
   logic       start0;
   logic       start1;
   logic       start2;
   logic       clr01;
   logic       clr2;
   logic [3:0] sw_n;

   // bit order: supply, upper, lower, detect, undetect, wake
   assign in_now = {internal_supply_detect, upper_storage_threshold, lower_storage_threshold,
                    power_detect_threshold, power_undetect_threshold, wake_request};
   assign rise   = in_now & ~s_q.in_q;

   // a timer completes on the cycle its count reaches the loaded duration
   assign done[0] = s_q.run[0] && (s_q.cnt0 >= hold_off_duration);
   assign done[1] = s_q.run[1] && (s_q.cnt1 >= on_window_duration);
   assign done[2] = s_q.run[2] && (s_q.cnt2 >= off_interval_duration);

   always_comb
   begin
      s_d         = s_q;
      s_d.in_q    = in_now;
      harvest     = ~battery_input_sel;
      up_ev       = harvest ? rise[4] : rise[2];
      lo_ev       = harvest ? rise[3] : rise[1];
      wake_ev     = rise[0];
      supply_loss = s_q.in_q[5] & ~internal_supply_detect;
      start0      = 1'b0;
      start1      = 1'b0;
      start2      = 1'b0;
      clr01       = 1'b0;
      clr2        = 1'b0;
      // straps: on-window open/closed, off-interval open/closed pick one of four modes
      if (rise[5] && !s_q.mode_set)
      begin
         s_d.mode_set = 1'b1;
         case ({on_window_strap, off_interval_strap})
            2'b00:   s_d.mode = MODE_ENERGY;
            2'b01:   s_d.mode = MODE_EVENT1;
            2'b10:   s_d.mode = MODE_EVENT2;
            default: s_d.mode = MODE_TIMER;
         endcase
      end
      if (up_ev)
         s_d.energy_on = 1'b1;
      else if (lo_ev)
         s_d.energy_on = 1'b0;
      case (s_q.mode)
         MODE_EVENT1:
         begin
            start0 = up_ev;
            clr01  = lo_ev;
         end
         MODE_EVENT2:
         begin
            start0 = up_ev;
            start1 = wake_ev && !s_q.run[0];
            clr01  = lo_ev;
            clr2   = lo_ev & ~harvest;
         end
         MODE_TIMER:
         begin
            start0 = (up_ev && !s_q.first_done) || done[2];
            start1 = start0;
            start2 = done[1];
            clr01  = lo_ev;
            clr2   = harvest ? supply_loss : lo_ev;
         end
         default:
         begin
            clr01 = 1'b1;
            clr2  = 1'b1;
         end
      endcase
      if (start0 && s_q.mode == MODE_TIMER)
         s_d.first_done = 1'b1;
      if (clr01)
         s_d.first_done = 1'b0;
      // completion stops and clears; clear beats start
      s_d.cnt0 = s_q.run[0] ? s_q.cnt0 + TIMER_ONE : TIMER_ZERO;
      s_d.cnt1 = s_q.run[1] ? s_q.cnt1 + TIMER_ONE : TIMER_ZERO;
      s_d.cnt2 = s_q.run[2] ? s_q.cnt2 + TIMER_ONE : TIMER_ZERO;
      if (done[0] || start0)
      begin
         s_d.run[0] = start0;
         s_d.cnt0   = TIMER_ONE;
      end
      if (done[1] || start1)
      begin
         s_d.run[1] = start1;
         s_d.cnt1   = TIMER_ONE;
      end
      if (done[2] || start2)
      begin
         s_d.run[2] = start2;
         s_d.cnt2   = TIMER_ONE;
      end
      if (clr01)
      begin
         s_d.run[1:0] = 2'b00;
         s_d.cnt0     = TIMER_ZERO;
         s_d.cnt1     = TIMER_ZERO;
      end
      if (clr2)
      begin
         s_d.run[2] = 1'b0;
         s_d.cnt2   = TIMER_ZERO;
      end
      // switch controls from flags, energy state and wake; sw = {store1, store2, bat1, bat2}
      sw_n = 4'h0;
      case (s_q.mode)
         MODE_ENERGY:
            sw_n = {4{s_q.energy_on}};
         MODE_EVENT1:
         begin
            sw_n[3] = s_q.energy_on;
            sw_n[1] = s_q.energy_on;
            // on start the hold-off flag masks wake until it ends
            sw_n[2] = s_q.energy_on & s_q.in_q[0] & ~s_q.run[0];
            sw_n[0] = s_q.energy_on & s_q.in_q[0] & ~s_q.run[0];
         end
         MODE_EVENT2:
         begin
            sw_n[3] = s_q.energy_on;
            sw_n[1] = s_q.energy_on;
            sw_n[2] = s_q.run[1];
            sw_n[0] = s_q.run[1];
         end
         MODE_TIMER:
         begin
            sw_n[3] = s_q.run[1] & ~s_q.run[2];
            sw_n[1] = s_q.run[1] & ~s_q.run[2];
            sw_n[2] = s_q.run[1] & ~s_q.run[0] & ~s_q.run[2];
            sw_n[0] = s_q.run[1] & ~s_q.run[0] & ~s_q.run[2];
         end
         default:
            sw_n = 4'h0;
      endcase
      s_d.sw = sw_n & (harvest ? 4'hC : 4'h3);
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         s_q      <= '0;
         s_q.mode <= MODE_ENERGY;
      end
      else
         s_q <= s_d;
   end

   assign op_mode                    = s_q.mode;
   assign hold_off_timer_flag        = s_q.run[0];
   assign on_window_timer_flag       = s_q.run[1];
   assign off_interval_timer_flag    = s_q.run[2];
   assign store_to_load_one_switch   = s_q.sw[3];
   assign store_to_load_two_switch   = s_q.sw[2];
   assign battery_to_load_one_switch = s_q.sw[1];
   assign battery_to_load_two_switch = s_q.sw[0];

   // durations are plain inputs so software-free straps can set them
   a_holdoff_ends: assert property (@(posedge clock) disable iff (sys_rst)
      done[0] && !start0 && !clr01 |=> !hold_off_timer_flag)
      else $error("hold-off flag stayed after completion");
   a_window_ends: assert property (@(posedge clock) disable iff (sys_rst)
      done[1] && !start1 && !clr01 |=> !on_window_timer_flag)
      else $error("on-window flag stayed after completion");
   a_off_ends: assert property (@(posedge clock) disable iff (sys_rst)
      done[2] && !start2 && !clr2 |=> !off_interval_timer_flag)
      else $error("off-interval flag stayed after completion");
   a_off_starts: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.mode == MODE_TIMER && done[1] && !clr2 |=> off_interval_timer_flag)
      else $error("off-interval did not start");
   a_timer_first: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.mode == MODE_TIMER && up_ev && !s_q.first_done && !lo_ev
      |=> hold_off_timer_flag && on_window_timer_flag)
      else $error("first threshold did not start timers");
   a_timer_restart: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.mode == MODE_TIMER && done[2] && !lo_ev
      |=> hold_off_timer_flag && on_window_timer_flag)
      else $error("off-interval end did not restart timers");
   a_timer_sw1: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.mode == MODE_TIMER && off_interval_timer_flag && !battery_input_sel
      |=> !store_to_load_one_switch)
      else $error("load one closed in off-interval");
   a_energy_sw: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.mode == MODE_ENERGY && !battery_input_sel
      |=> store_to_load_one_switch == $past(s_q.energy_on)
      && store_to_load_two_switch == $past(s_q.energy_on))
      else $error("energy mode store switches off track");
   a_ev1_start: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.mode == MODE_EVENT1 && up_ev && !lo_ev |=> hold_off_timer_flag)
      else $error("hold-off did not start on threshold");
   a_ev1_wake: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.mode == MODE_EVENT1 && s_q.energy_on && s_q.in_q[0] && !hold_off_timer_flag
      |=> store_to_load_two_switch || battery_to_load_two_switch)
      else $error("wake did not close load two");
   a_ev2_start: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.mode == MODE_EVENT2 && wake_ev && !hold_off_timer_flag && !lo_ev
      |=> on_window_timer_flag)
      else $error("wake did not open the on-window");
   a_ev2_sw: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.mode == MODE_EVENT2 && !battery_input_sel |=>
      store_to_load_two_switch == $past(on_window_timer_flag))
      else $error("load two not following on-window");
   a_ev2_mask: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.mode == MODE_EVENT2 && hold_off_timer_flag && !on_window_timer_flag
      && !done[0] |=> !on_window_timer_flag)
      else $error("wake started on-window in hold-off");
   a_ev1_mask: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.mode == MODE_EVENT1 && hold_off_timer_flag |=> !store_to_load_two_switch
      && !battery_to_load_two_switch)
      else $error("wake passed during hold-off");
   a_lower_clear: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.mode != MODE_ENERGY && lo_ev |=> !hold_off_timer_flag && !on_window_timer_flag)
      else $error("lower threshold did not clear timers");
   a_mode_hold: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.mode_set |=> $stable(op_mode))
      else $error("mode changed after latch");
   c_timer_cycle: cover property (@(posedge clock) disable iff (sys_rst)
      s_q.mode == MODE_TIMER && done[2]);
   c_ev2_window: cover property (@(posedge clock) disable iff (sys_rst)
      s_q.mode == MODE_EVENT2 && done[1]);
   c_ev1_wake: cover property (@(posedge clock) disable iff (sys_rst)
      s_q.mode == MODE_EVENT1 && store_to_load_two_switch);
   c_energy_on: cover property (@(posedge clock) disable iff (sys_rst)
      s_q.mode == MODE_ENERGY && up_ev);
   c_ev2_cleared: cover property (@(posedge clock) disable iff (sys_rst)
      s_q.mode == MODE_EVENT2 && lo_ev && on_window_timer_flag);

endmodule : power_gating_sequencer
`default_nettype wire

// ---- tb/wake_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module wake_source
(
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       start,
   input  wire logic [7:0] hold,
   output logic            wake_request
);
   logic [7:0] left_q;
   // the sensor holds wake as a plain level for a set span, low out of reset
   always @(posedge clock)
   begin
      if (sys_rst)
         left_q <= 8'h00;
      else if (start)
         left_q <= hold;
      else if (left_q != 8'h00)
         left_q <= left_q - 8'h01;
   end
   assign wake_request = (left_q != 8'h00);
endmodule : wake_source
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pg_pkg::*;
   localparam int HOLD_LEN = 8, WIN_LEN = 10, OFF_LEN = 8;
   logic       clock = 0, sys_rst = 1, bsel = 0, supply = 0, s_on = 0, s_off = 0, start = 0;
   logic [3:0] thr   = 4'h0;
   logic [7:0] hold  = 8'h00;
   wire logic       wake;
   wire logic [3:0] op_mode;
   wire logic [2:0] flg;
   wire logic [3:0] sw;
   int         error_cnt = 0, n_tests = 0, cycles = 0, n, up, dn;
   always #50 clock = ~clock;
   wake_source u_wake_source (.clock(clock), .sys_rst(sys_rst), .start(start), .hold(hold),
      .wake_request(wake));
   power_gating_sequencer u_power_gating_sequencer (.clock(clock), .sys_rst(sys_rst),
      .battery_input_sel(bsel), .internal_supply_detect(supply), .on_window_strap(s_on),
      .off_interval_strap(s_off), .upper_storage_threshold(thr[0]),
      .lower_storage_threshold(thr[1]), .power_detect_threshold(thr[2]),
      .power_undetect_threshold(thr[3]), .wake_request(wake),
      .hold_off_duration(24'(HOLD_LEN)), .on_window_duration(24'(WIN_LEN)),
      .off_interval_duration(24'(OFF_LEN)), .op_mode(op_mode), .hold_off_timer_flag(flg[0]),
      .on_window_timer_flag(flg[1]), .off_interval_timer_flag(flg[2]),
      .store_to_load_one_switch(sw[0]), .store_to_load_two_switch(sw[1]),
      .battery_to_load_one_switch(sw[2]), .battery_to_load_two_switch(sw[3]));
   task give_verdict;
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         give_verdict();
      end
   end
   task cyc(input int k);
      repeat (k) @(posedge clock);
      #5;
   endtask : cyc
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
         error_cnt++;
      end
   endtask : chk
   function automatic logic [3:0] pair(input int b, input logic one, input logic two);
      return (b != 0) ? {two, one, 2'b00} : {2'b00, two, one};
   endfunction : pair
   task pulse(input int k);
      thr[k] = 1'b1;
      cyc(2);
      thr[k] = 1'b0;
   endtask : pulse
   task wake_for(input logic [7:0] h);
      start = 1'b1;
      hold = h;
      cyc(1);
      start = 1'b0;
   endtask : wake_for
   // counts from the current sample, so a flag already high is only partly counted
   task measure(input int k, output int len);
      int w;
      w = 0;
      len = 0;
      while (flg[k] !== 1'b1 && w < 50)
      begin
         w++;
         cyc(1);
      end
      while (flg[k] === 1'b1 && len < 100)
      begin
         len++;
         cyc(1);
      end
   endtask : measure
   task setup(input logic [1:0] m, input int b);
      sys_rst = 1'b1;
      supply = 1'b0;
      bsel = (b != 0);
      {s_on, s_off} = m;
      thr = 4'h0;
      cyc(6);
      sys_rst = 1'b0;
      cyc(2);
      supply = 1'b1;
      cyc(3);
      // straps move after the latch point and must not disturb the mode
      {s_on, s_off} = ~m;
      cyc(2);
      chk("op_mode", {4'h0, op_mode}, {4'h0, 4'h1 << m});
   endtask : setup
   initial
   begin
      for (int b = 0; b < 2; b++)
      begin
         up = (b != 0) ? 2 : 0;
         dn = (b != 0) ? 3 : 1;
         setup(2'd0, b);
         pulse(up);
         cyc(2);
         chk("energy on", {4'h0, sw}, {4'h0, pair(b, 1, 1)});
         pulse(dn);
         cyc(2);
         chk("energy off", {4'h0, sw}, {4'h0, pair(b, 0, 0)});
         setup(2'd1, b);
         pulse(up);
         wake_for(8'd30);
         cyc(2);
         chk("ev1 hold-off", {4'h0, sw}, {4'h0, pair(b, 1, 0)});
         measure(0, n);
         chk("ev1 hold-off len", 8'(n), 8'(HOLD_LEN - 4));
         cyc(3);
         chk("ev1 wake", {4'h0, sw}, {4'h0, pair(b, 1, 1)});
         cyc(25);
         chk("ev1 wake low", {4'h0, sw}, {4'h0, pair(b, 1, 0)});
         setup(2'd2, b);
         pulse(up);
         wake_for(8'd2);
         cyc(3);
         chk("ev2 blocked", {7'h00, flg[1]}, 8'h00);
         measure(0, n);
         cyc(1);
         wake_for(8'd2);
         cyc(3);
         chk("ev2 window", {4'h0, sw}, {4'h0, pair(b, 1, 1)});
         measure(1, n);
         chk("ev2 window len", 8'(n), 8'(WIN_LEN - 2));
         cyc(2);
         chk("ev2 closed", {4'h0, sw}, {4'h0, pair(b, 1, 0)});
         wake_for(8'd2);
         cyc(3);
         pulse(dn);
         cyc(1);
         chk("ev2 cleared", {5'h00, flg}, 8'h00);
         setup(2'd3, b);
         pulse(up);
         measure(0, n);
         chk("tm hold-off len", 8'(n), 8'(HOLD_LEN - 1));
         // load two follows the hold-off flag one edge late
         chk("tm load two held", {4'h0, sw}, {4'h0, pair(b, 1, 0)});
         cyc(1);
         chk("tm on", {4'h0, sw}, {4'h0, pair(b, 1, 1)});
         measure(1, n);
         cyc(2);
         chk("tm off", {4'h0, sw}, {4'h0, pair(b, 0, 0)});
         measure(2, n);
         chk("tm off len", 8'(n), 8'(OFF_LEN - 2));
         measure(1, n);
         chk("tm restart len", 8'(n), 8'(WIN_LEN));
         pulse(dn);
         cyc(1);
         chk("tm off kept", {7'h00, flg[2]}, (b != 0) ? 8'h00 : 8'h01);
         supply = 1'b0;
         cyc(2);
         chk("tm supply loss", {5'h00, flg}, 8'h00);
      end
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
